//--- logic/comparator_subsystem.sv
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none
module comparator_subsystem (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_raw,
   input wire logic pwm_sync_pulse,
   output logic trip_out,
   output logic [cmp_trip_pkg::dac_w-1:0] dac_value,
   output logic irq
);
   logic cmp_meta;
   logic cmp_sync;
   logic filt;
   logic trip_latch;
   logic high_comparator_trip_flag;
   logic latch_enable;
   logic sw_clear;
   logic filter_flush;
   cmp_trip_pkg::filter_cfg_t fcfg;
   logic [cmp_trip_pkg::dac_w-1:0] ramp_start;
   logic [cmp_trip_pkg::dac_w-1:0] ramp_step;
   cmp_trip_pkg::ramp_state_t ramp_state;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [1:0] irq_events;
   logic trip_rise;
   logic ramp_stop;
   logic wr;
   logic rd;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   // Comparator crosses from the analog domain: two flops first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end
      else
      begin
         cmp_meta <= cmp_raw;
         cmp_sync <= cmp_meta;
      end
   end
   trip_filter #(.depth(32)) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .sample_in(cmp_sync),
      .cfg(fcfg),
      .flush(filter_flush),
      .filt_out(filt)
   );
   assign sw_clear = wr && (paddr == cmp_trip_pkg::off_status_clear) && pwdata[cmp_trip_pkg::clear_latch_bit];
   // Set wins over clear, so a filter still at 1 re-arms the latch on the next cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trip_latch <= 1'b0;
      else if (filt && latch_enable)
         trip_latch <= 1'b1;
      else if (sw_clear || pwm_sync_pulse)
         trip_latch <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trip_out <= 1'b0;
         high_comparator_trip_flag <= 1'b0;
      end
      else
      begin
         trip_out <= latch_enable ? trip_latch : filt;
         high_comparator_trip_flag <= filt && !(latch_enable && trip_latch);
      end
   end
   // Ramp: the trip check sits ahead of the sync check, reproducing the shipped priority
   assign ramp_stop = high_comparator_trip_flag;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ramp_state <= cmp_trip_pkg::ramp_idle;
         dac_value <= cmp_trip_pkg::ramp_start_reset;
      end
      else
      begin
         case (ramp_state)
            cmp_trip_pkg::ramp_idle:
            begin
               if (pwm_sync_pulse && !ramp_stop)
               begin
                  ramp_state <= cmp_trip_pkg::ramp_run;
                  dac_value <= ramp_start;
               end
            end
            cmp_trip_pkg::ramp_run:
            begin
               if (ramp_stop)
                  ramp_state <= cmp_trip_pkg::ramp_idle;
               else if (pwm_sync_pulse)
                  dac_value <= ramp_start;
               else if (dac_value > ramp_step)
                  dac_value <= dac_value - ramp_step;
               else
               begin
                  dac_value <= '0;
                  ramp_state <= cmp_trip_pkg::ramp_idle;
               end
            end
            default:
               ramp_state <= cmp_trip_pkg::ramp_idle;
         endcase
      end
   end
   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latch_enable <= 1'b1;
         fcfg.divider <= cmp_trip_pkg::filter_div_reset;
         fcfg.thresh <= cmp_trip_pkg::filter_vote_threshold_reset;
         ramp_start <= cmp_trip_pkg::ramp_start_reset;
         ramp_step <= cmp_trip_pkg::ramp_step_reset;
         irq_mask <= 2'h0;
         filter_flush <= 1'b0;
      end
      else
      begin
         filter_flush <= 1'b0;
         if (wr)
         begin
            case (paddr)
               cmp_trip_pkg::off_ctrl:
                  latch_enable <= pwdata[0];
               cmp_trip_pkg::off_filter_ctrl:
               begin
                  fcfg.divider <= pwdata[cmp_trip_pkg::div_w-1:0];
                  fcfg.thresh <= pwdata[8 +: cmp_trip_pkg::win_w];
                  filter_flush <= pwdata[cmp_trip_pkg::filter_init_bit];
               end
               cmp_trip_pkg::off_ramp_start:
                  ramp_start <= pwdata[cmp_trip_pkg::dac_w-1:0];
               cmp_trip_pkg::off_ramp_step:
                  ramp_step <= pwdata[cmp_trip_pkg::dac_w-1:0];
               cmp_trip_pkg::off_irq_mask:
                  irq_mask <= pwdata[1:0];
               default:
                  ;
            endcase
         end
      end
   end
   // Interrupt events: latch rising and ramp stopped by trip; read clears, event wins
   assign trip_rise = filt && latch_enable && !trip_latch;
   assign irq_events = {ramp_stop && ramp_state == cmp_trip_pkg::ramp_run, trip_rise};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= 2'h0;
      else if (rd && paddr == cmp_trip_pkg::off_irq_status)
         irq_status <= irq_events;
      else
         irq_status <= irq_status | irq_events;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |((irq_status | irq_events) & irq_mask);
   end
   // Zero wait states: pready is a registered pulse in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               cmp_trip_pkg::off_ctrl:
                  prdata <= {31'h0, latch_enable};
               cmp_trip_pkg::off_status:
                  prdata <= {29'h0, ramp_state == cmp_trip_pkg::ramp_run, trip_latch, filt};
               cmp_trip_pkg::off_filter_ctrl:
                  prdata <= {19'h0, fcfg.thresh, fcfg.divider};
               cmp_trip_pkg::off_ramp_start:
                  prdata <= {20'h0, ramp_start};
               cmp_trip_pkg::off_ramp_step:
                  prdata <= {20'h0, ramp_step};
               cmp_trip_pkg::off_ramp_value:
                  prdata <= {20'h0, dac_value};
               cmp_trip_pkg::off_irq_status:
                  prdata <= {30'h0, irq_status};
               cmp_trip_pkg::off_irq_mask:
                  prdata <= {30'h0, irq_mask};
               cmp_trip_pkg::off_status_clear:
                  prdata <= 32'h0000_0000;
               default:
                  pslverr <= 1'b1;
            endcase
         end
         else if (psel && !penable && pwrite)
            pslverr <= !(paddr inside {cmp_trip_pkg::off_ctrl, cmp_trip_pkg::off_status_clear,
               cmp_trip_pkg::off_filter_ctrl, cmp_trip_pkg::off_ramp_start, cmp_trip_pkg::off_ramp_step,
               cmp_trip_pkg::off_irq_mask});
      end
   end
   latch_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sw_clear && !(filt && latch_enable)) |=> !trip_latch) else $error("latch not cleared");
   relatch_a: assert property (@(posedge pclk) disable iff (!presetn)
      (filt && latch_enable) |=> trip_latch) else $error("filter high did not set latch");
   latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trip_latch && !sw_clear && !pwm_sync_pulse) |=> trip_latch) else $error("latch dropped");
   latch_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(trip_latch) |-> $past(filt)) else $error("latch set without filter");
   flush_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
      filter_flush |=> !filt) else $error("flush left filter high");
   sync_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pwm_sync_pulse && !ramp_stop) |=> (dac_value == $past(ramp_start))) else $error("ramp not reloaded");
   trip_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ramp_stop && pwm_sync_pulse) |=> ramp_state == cmp_trip_pkg::ramp_idle) else $error("sync beat trip");
   ramp_falls_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ramp_state == cmp_trip_pkg::ramp_run && !ramp_stop && !pwm_sync_pulse) |=>
      dac_value == (($past(dac_value) > $past(ramp_step)) ? $past(dac_value) - $past(ramp_step) : 12'h000))
      else $error("ramp step wrong");
   status_view_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == cmp_trip_pkg::off_status) |=> prdata[0] == $past(filt))
      else $error("status misses filter");
endmodule // comparator_subsystem
`default_nettype wire

//--- logic/cmp_trip_pkg.sv
// Behaviour
// - Trip latch holds until software clear or pwm sync pulse clears it.
// - Latch is set only from the filtered comparator, never the raw input.
// - Input-to-latch delay at most 3 + (threshold+1) times (divider+1) cycles.
// - After a clear the filter may still show stale state for the latency.
// - Filter output high when latch clears sets the latch again next cycle.
// - Comparator status register shows the current filter output.
// - Reinitialising the filter through trip filter control flushes its history.
// - Ramp generator produces a falling DAC reference tied to the sync pulse.
// - Each sync pulse starts the ramp decrementing unless the high comparator trip flag is set.
// - A high comparator trip flag stops the ramp decrementing.
// - Intended: a coincident sync pulse would win over a trip.
// - As built, a coincident trip wins; ramp stays stopped until next sync.
`default_nettype none
package cmp_trip_pkg;
   localparam logic [11:0] off_ctrl = 12'h000;
   localparam logic [11:0] off_status = 12'h004;
   localparam logic [11:0] off_status_clear = 12'h008;
   localparam logic [11:0] off_filter_ctrl = 12'h00c;
   localparam logic [11:0] off_ramp_start = 12'h010;
   localparam logic [11:0] off_ramp_step = 12'h014;
   localparam logic [11:0] off_ramp_value = 12'h018;
   localparam logic [11:0] off_irq_status = 12'h01c;
   localparam logic [11:0] off_irq_mask = 12'h020;
   localparam int dac_w = 12;
   localparam int div_w = 8;
   localparam int win_w = 5;
   localparam int status_filter_bit = 0;
   localparam int status_latch_bit = 1;
   localparam int status_ramp_bit = 2;
   localparam int clear_latch_bit = 0;
   localparam int filter_init_bit = 31;
   localparam int irq_trip_bit = 0;
   localparam int irq_stop_bit = 1;
   localparam logic [dac_w-1:0] ramp_start_reset = 12'hfff;
   localparam logic [dac_w-1:0] ramp_step_reset = 12'h001;
   localparam logic [div_w-1:0] filter_div_reset = 8'h00;
   localparam logic [win_w-1:0] filter_vote_threshold_reset = 5'h00;
   typedef struct packed
   {
      logic [div_w-1:0] divider;
      logic [win_w-1:0] thresh;
   } filter_cfg_t;
   typedef enum logic [1:0]
   {
      ramp_idle = 2'b01,
      ramp_run = 2'b10
   } ramp_state_t;
endpackage
`default_nettype wire

//--- logic/trip_filter.sv
`default_nettype none
// Unanimous-vote filter: output goes 1 when more than thresh of last window samples are 1
module trip_filter #(
   parameter int depth = 32
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample_in,
   input wire cmp_trip_pkg::filter_cfg_t cfg,
   input wire logic flush,
   output logic filt_out
);
   logic [cmp_trip_pkg::div_w-1:0] div_cnt;
   logic [depth-1:0] hist;
   logic [5:0] ones;
   logic [5:0] zeros;
   logic tick;
   assign tick = (div_cnt == cfg.divider);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_cnt <= '0;
      else if (flush || tick)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + 8'h01;
   end
   // Window length is thresh+1 samples; vote needs all to agree to change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hist <= '0;
         filt_out <= 1'b0;
      end
      else if (flush)
      begin
         hist <= '0;
         filt_out <= 1'b0;
      end
      else if (tick)
      begin
         hist <= {hist[depth-2:0], sample_in};
         if (ones > {1'b0, cfg.thresh})
            filt_out <= 1'b1;
         else if (zeros > {1'b0, cfg.thresh})
            filt_out <= 1'b0;
      end
   end
   always_comb
   begin
      ones = 6'h00;
      zeros = 6'h00;
      for (int i = 0; i < depth; i++)
      begin
         if (i <= int'(cfg.thresh))
         begin
            if (i == 0 ? sample_in : hist[i-1])
               ones = ones + 6'h01;
            else
               zeros = zeros + 6'h01;
         end
      end
   end
endmodule // trip_filter
`default_nettype wire

//--- tb/pwm_model.sv
`default_nettype none
module pwm_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [7:0] period,
   output logic pwm_sync_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] count;
   // One-cycle sync each period, low while stopped
   // Sync timing ignores trips, so the bench keeps trips clear of it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= 8'h00;
         pwm_sync_pulse <= 1'b0;
      end
      else
      begin
         count <= (run && count != period - 8'h01) ? count + 8'h01 : 8'h00;
         pwm_sync_pulse <= run && count == period - 8'h01;
      end
   end
endmodule // pwm_model
`default_nettype wire

//--- tb/comparator_subsystem_test.sv
`default_nettype none
module comparator_subsystem_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic err;} row_t;
   logic pclk, presetn, psel, penable, pwrite, cmp_raw, run, sync, pready, pslverr, trip_out, irq, err;
   logic [11:0] paddr, dac_value, v;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] period;
   int miscompares = 0;
   int n_compared = 0;
   row_t rows[14] = '{'{1'b0, 12'h000, 32'h1, 1'b0}, '{1'b0, 12'h004, 32'h0, 1'b0},
      '{1'b0, 12'h010, 32'hfff, 1'b0}, '{1'b0, 12'h014, 32'h1, 1'b0}, '{1'b0, 12'h018, 32'hfff, 1'b0},
      '{1'b0, 12'h020, 32'h0, 1'b0}, '{1'b0, 12'h024, 32'h0, 1'b1}, '{1'b1, 12'h024, 32'h5, 1'b1},
      '{1'b1, 12'h010, 32'h10, 1'b0}, '{1'b1, 12'h014, 32'h4, 1'b0}, '{1'b1, 12'h020, 32'h3, 1'b0},
      '{1'b0, 12'h010, 32'h10, 1'b0}, '{1'b0, 12'h014, 32'h4, 1'b0}, '{1'b0, 12'h020, 32'h3, 1'b0}};
   comparator_subsystem dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .pwm_sync_pulse(sync), .trip_out(trip_out), .dac_value(dac_value), .irq(irq));
   pwm_model pwm (.pclk(pclk), .presetn(presetn), .run(run), .period(period), .pwm_sync_pulse(sync));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Request held until the edge that samples pready high; data taken at that same edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1)
         miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_for(input logic on_sync, input int lim);
      int n;
      n = 0;
      @(negedge pclk);
      while ((on_sync ? sync : trip_out) !== 1'b1 && n < lim)
      begin
         @(negedge pclk);
         n++;
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial
   begin
      repeat (3000) @(posedge pclk);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, cmp_raw, run} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      period = 8'h28;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk("pslverr", rows[i].err, err);
         if (!rows[i].wr)
            chk("prdata", rows[i].d, rd);
      end
      $display("test registers done");
      cmp_raw <= 1'b1;
      wait_for(1'b0, 6);
      chk("trip", 1, trip_out);
      chk("irq", 1, irq);
      apb(1'b0, 12'h004, 0);
      chk("status", 3, rd[2:0]);
      cmp_raw <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("held", 1, trip_out);
      apb(1'b0, 12'h01c, 0);
      chk("irq status", 1, rd[1:0]);
      apb(1'b0, 12'h01c, 0);
      chk("irq cleared", 0, {rd[1:0], irq});
      apb(1'b1, 12'h008, 0);
      chk("zero write", 1, trip_out);
      apb(1'b1, 12'h008, 1);
      repeat (2) @(negedge pclk);
      chk("cleared", 0, trip_out);
      @(posedge pclk);
      cmp_raw <= 1'b1;
      wait_for(1'b0, 6);
      apb(1'b1, 12'h008, 1);
      repeat (2) @(negedge pclk);
      chk("reset again", 1, trip_out);
      $display("test latch done");
      // Divider 3 and threshold 2: samples every 4 clocks, 3 in a row must agree
      apb(1'b1, 12'h00c, 32'h203);
      cmp_raw <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h004, 0);
      chk("filter settled", 0, rd[0]);
      apb(1'b1, 12'h008, 1);
      cmp_raw <= 1'b1;
      repeat (3) @(posedge pclk);
      cmp_raw <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("glitch", 0, trip_out);
      cmp_raw <= 1'b1;
      wait_for(1'b0, 20);
      chk("slow trip", 1, trip_out);
      @(posedge pclk);
      cmp_raw <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b1, 12'h00c, 32'h8000_0203);
      apb(1'b0, 12'h004, 0);
      chk("flushed", 0, rd[0]);
      apb(1'b1, 12'h00c, 32'h8000_0000);
      apb(1'b1, 12'h008, 1);
      $display("test filter done");
      run <= 1'b1;
      wait_for(1'b1, 50);
      for (int k = 0; k < 6; k++)
      begin
         @(negedge pclk);
         chk("ramp", (k < 5) ? 12'h010 - 12'h004 * k : 12'h000, dac_value);
      end
      apb(1'b0, 12'h004, 0);
      chk("ramp idle", 0, rd[2]);
      apb(1'b1, 12'h010, 32'h100);
      apb(1'b1, 12'h014, 32'h1);
      wait_for(1'b1, 50);
      @(negedge pclk);
      chk("reload", 12'h100, dac_value);
      @(posedge pclk);
      cmp_raw <= 1'b1;
      repeat (12) @(negedge pclk);
      v = dac_value;
      repeat (5) @(negedge pclk);
      chk("stopped", {1'b1, v}, {v != 12'h100, dac_value});
      apb(1'b0, 12'h01c, 0);
      chk("stop event", 3, rd[1:0]);
      cmp_raw <= 1'b0;
      wait_for(1'b1, 50);
      repeat (2) @(negedge pclk);
      chk("sync clear", {1'b0, 12'h0ff}, {trip_out, dac_value});
      run <= 1'b0;
      $display("test ramp done");
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk("reset", {1'b0, 12'hfff}, {trip_out, dac_value});
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h010, 0);
      chk("reset start", 32'hfff, rd);
      $display("test reset done");
      end_of_test();
   end
endmodule // comparator_subsystem_test
`default_nettype wire
